// file: hw/kds_debounce.sv
/*
 * Per-return-line debounce and closure pulse for one matrix column.
 * Assumes the caller pulses sample_i once per strobe step and frame_i
 * once per complete scan, on the last step of that scan.
 */
`timescale 1ns/1ps
`default_nettype none
module kds_debounce #(
   parameter int unsigned FRAMES = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sample_i,
   input wire logic pressed_i,
   input wire logic frame_i,
   output logic accept_o
);
   logic [7:0] count_reg;
   logic seen_reg;
   logic done_reg;
   logic hit;
   logic ready;

   assign hit = sample_i & pressed_i;
   // R17 delay before accept
   // First scan may be partial, so one more is counted
   assign ready = !done_reg && count_reg > 8'(FRAMES);

   // R19 whole-frame debounce
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_reg <= 8'h00;
         seen_reg <= 1'b0;
         done_reg <= 1'b0;
         accept_o <= 1'b0;
      end else begin
         accept_o <= hit && ready;
         if (hit && ready) begin
            done_reg <= 1'b1;
         end
         if (frame_i) begin
            seen_reg <= 1'b0;
            if (!seen_reg && !hit) begin
               count_reg <= 8'h00;
               done_reg <= 1'b0;
            end else if (count_reg <= 8'(FRAMES)) begin
               count_reg <= count_reg + 8'h01;
            end
         end else if (hit) begin
            seen_reg <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// file: hw/kds_pkg.sv
/*
 * Shared constants for the keyboard and display scanner.
 * Assumes a 100 MHz system clock and a synchronous active-high reset.
 */
//
// Notes on behaviour
// R1 - Selected when bus bits 4..6 match straps and write qualifier and bit 7 high.
// R2 - When selected, bus bits 0..3 pick one of eight commands.
// R3 - Bit-time counter divides clock by eight, one pulse per bit time.
// R4 - Scan counter advances once every eight bit times, times all scanning.
// R5 - Scan value names a key; on closure it enters first key stage.
// R6 - Display control loads, shifts, holds, enables, disables both stores by command.
// R7 - Two stores of sixteen 4-bit entries, written only from bus bits 4..7.
// R8 - Each store drives its entry on four open-drain outputs with the strobe.
// R9 - Bank select low picks lower eight positions, high the upper eight.
// R10 - Strobes assert one at a time from first to last, then wrap.
// R11 - Returns sampled during each strobe feed key closure detection.
// R12 - Nine-stage 8-bit FIFO; codes ripple forward into empty stages.
// R13 - Full buffer plus new key sets top bit of ninth code.
// R14 - Clear-overflow command clears the flag; first eight entries stay valid.
// R15 - Read request drives the oldest code from the last stage onto the bus.
// R16 - Host reads a key location by two load commands: strobe then returns.
// R17 - Debounce of 7.68 ms before a closure is accepted.
// R18 - Power-on sync initializes counters and buffers.
// R19 - Debounce counted in whole scan cycles; return must stay active throughout.
package kds_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned BIT_DIV = 8;
   localparam int unsigned SCAN_DIV = 8;
   localparam int unsigned FIFO_DEPTH = 9;
   // Debounce time in microseconds
   localparam int unsigned DEBOUNCE_US = 7680;
   // Clock cycles per scan step and per full 256-step scan
   localparam int unsigned STEP_CYCLES = BIT_DIV * SCAN_DIV;
   localparam int unsigned FRAME_CYCLES = STEP_CYCLES * 256;
   localparam int unsigned DEBOUNCE_CYCLES =
      (DEBOUNCE_US * (CLK_HZ / 1_000_000));
   // Whole scan frames, rounded up
   localparam int unsigned DEBOUNCE_FRAMES =
      (DEBOUNCE_CYCLES + FRAME_CYCLES - 1) / FRAME_CYCLES;

   // Commands on bus bits 0..3
   localparam logic [3:0] CMD_READ_KEY = 4'h0;
   localparam logic [3:0] CMD_CLEAR_OVF = 4'h1;
   localparam logic [3:0] CMD_LOAD_A = 4'h2;
   localparam logic [3:0] CMD_LOAD_B = 4'h3;
   localparam logic [3:0] CMD_DISP_ON = 4'h4;
   localparam logic [3:0] CMD_DISP_OFF = 4'h5;
   localparam logic [3:0] CMD_READ_STROBE = 4'h6;
   localparam logic [3:0] CMD_READ_RETURN = 4'h7;

   // Wishbone register byte offsets
   localparam logic [3:0] REG_CMD = 4'h0;
   localparam logic [3:0] REG_DATA = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam logic [3:0] REG_STRAP = 4'hC;

   localparam logic [2:0] STRAP_RESET = 3'h0;
   localparam logic [7:0] DATA_RESET = 8'h00;
endpackage

// file: hw/kds_top.sv
/*
 * Keyboard and display scanner with a Wishbone slave.
 * Registers: CMD (write: bits 3:0 command, 7:4 data, write bus image),
 * DATA (read: last command answer), STATUS, STRAP (select straps).
 * Assumes classic Wishbone, 32-bit data, one clock.
 */
`timescale 1ns/1ps
`default_nettype none
module kds_top #(
   // Whole scans of debounce; a short value only speeds up simulation
   parameter int unsigned DEBOUNCE_FRAMES = kds_pkg::DEBOUNCE_FRAMES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic power_on_sync_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   input wire logic [7:0] return_in_i,
   output logic [7:0] strobe_o,
   output logic [7:0] strobe_oe_o,
   output logic bank_select_out_o,
   output logic [3:0] group_a_digit_out_o,
   output logic [3:0] group_a_digit_oe_o,
   output logic [3:0] group_b_digit_out_o,
   output logic [3:0] group_b_digit_oe_o
);
   ////////////////////////////////////////////////////////////////////////
   logic init;
   logic [2:0] bit_cnt_reg;
   logic [2:0] step_cnt_reg;
   logic [7:0] scan_reg;
   logic bit_tick;
   logic step_tick;
   logic frame_tick;
   logic [2:0] strap_reg;
   logic [7:0] data_out_reg;
   logic disp_on_reg;
   logic [3:0] store_a [16];
   logic [3:0] store_b [16];
   logic [7:0] fifo_reg [9];
   logic [8:0] full_reg;
   logic [7:0] accept;
   logic key_event;
   logic [7:0] key_code;
   logic wb_req;
   logic wb_wr;
   logic wb_rd;
   logic sel;
   logic [3:0] cmd;
   logic [3:0] cmd_data;
   logic pop;
   logic [7:0] sample_reg;
   logic [2:0] strobe_pos_reg;

   // R18 power-on init
   assign init = rst_i | power_on_sync_i;

   ////////////////////////////////////////////////////////////////////////
   // Wishbone decode
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];
   assign wb_rd = wb_req & ~wb_we_i;
   // R1 chip select
   assign sel = wb_wr && wb_adr_i[3:0] == kds_pkg::REG_CMD &&
      wb_dat_i[6:4] == strap_reg && wb_dat_i[8] && wb_dat_i[7];
   // R2 command field
   assign cmd = wb_dat_i[3:0];
   assign cmd_data = wb_dat_i[7:4];
   assign pop = sel && cmd == kds_pkg::CMD_READ_KEY;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_rd) begin
         unique case (wb_adr_i[3:0])
            kds_pkg::REG_DATA: wb_dat_o <= {24'h00_0000, data_out_reg};
            kds_pkg::REG_STATUS:
               wb_dat_o <= {22'h00_0000, disp_on_reg, full_reg};
            kds_pkg::REG_STRAP: wb_dat_o <= {29'h0000_0000, strap_reg};
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strap_reg <= kds_pkg::STRAP_RESET;
      end else if (wb_wr && wb_adr_i[3:0] == kds_pkg::REG_STRAP) begin
         strap_reg <= wb_dat_i[2:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // R3 bit-time divider
   assign bit_tick = bit_cnt_reg == 3'(kds_pkg::BIT_DIV - 1);
   // R4 scan step every eight bit times
   assign step_tick = bit_tick && step_cnt_reg == 3'(kds_pkg::SCAN_DIV - 1);
   assign frame_tick = step_tick && scan_reg == 8'hFF;

   always_ff @(posedge clk_i) begin
      if (init) begin
         bit_cnt_reg <= 3'h0;
         step_cnt_reg <= 3'h0;
         scan_reg <= 8'h00;
      end else begin
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         if (bit_tick) begin
            step_cnt_reg <= step_cnt_reg + 3'h1;
         end
         if (step_tick) begin
            scan_reg <= scan_reg + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // R10 strobe walk, R9 bank select
   always_ff @(posedge clk_i) begin
      if (init) begin
         strobe_o <= 8'h00;
         strobe_oe_o <= 8'h00;
         bank_select_out_o <= 1'b0;
      end else begin
         strobe_o <= 8'h00;
         strobe_oe_o <= 8'h01 << scan_reg[2:0];
         bank_select_out_o <= scan_reg[3];
      end
   end

   // R8 open-drain digit drive
   always_ff @(posedge clk_i) begin
      if (init) begin
         group_a_digit_out_o <= 4'h0;
         group_a_digit_oe_o <= 4'h0;
         group_b_digit_out_o <= 4'h0;
         group_b_digit_oe_o <= 4'h0;
      end else begin
         group_a_digit_out_o <= 4'h0;
         group_b_digit_out_o <= 4'h0;
         group_a_digit_oe_o <= disp_on_reg ? store_a[scan_reg[3:0]] : 4'h0;
         group_b_digit_oe_o <= disp_on_reg ? store_b[scan_reg[3:0]] : 4'h0;
      end
   end

   // R6 display on and off
   always_ff @(posedge clk_i) begin
      if (init) begin
         disp_on_reg <= 1'b1;
      end else if (sel && cmd == kds_pkg::CMD_DISP_ON) begin
         disp_on_reg <= 1'b1;
      end else if (sel && cmd == kds_pkg::CMD_DISP_OFF) begin
         disp_on_reg <= 1'b0;
      end
   end

   // R7 stores loaded by shifting in bus nibbles
   always_ff @(posedge clk_i) begin
      if (init) begin
         for (int i = 0; i < 16; i++) begin
            store_a[i] <= 4'h0;
            store_b[i] <= 4'h0;
         end
      end else if (sel && cmd == kds_pkg::CMD_LOAD_A) begin
         for (int i = 0; i < 15; i++) begin
            store_a[i] <= store_a[i + 1];
         end
         store_a[15] <= cmd_data;
      end else if (sel && cmd == kds_pkg::CMD_LOAD_B) begin
         for (int i = 0; i < 15; i++) begin
            store_b[i] <= store_b[i + 1];
         end
         store_b[15] <= cmd_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // R11 return sampling per strobe, latest image kept
   always_ff @(posedge clk_i) begin
      if (init) begin
         sample_reg <= 8'h00;
         strobe_pos_reg <= 3'h0;
      end else if (step_tick) begin
         sample_reg <= return_in_i;
         // Scan has moved on when an accept arrives
         strobe_pos_reg <= scan_reg[2:0];
      end
   end

   // R11 per-return debounce, sampled at end of each strobe
   for (genvar g = 0; g < 8; g++) begin : g_db
      kds_debounce #(
         .FRAMES(DEBOUNCE_FRAMES)
      ) u_db (
         .clk_i(clk_i),
         .rst_i(init),
         .sample_i(step_tick),
         .pressed_i(return_in_i[g]),
         .frame_i(frame_tick),
         .accept_o(accept[g])
      );
   end

   // R5 key code from scan position of lowest accepted return
   always_comb begin
      key_event = 1'b0;
      key_code = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         if (accept[i]) begin
            key_event = 1'b1;
            key_code = {2'b00, 3'(i), strobe_pos_reg};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // R12 nine-stage ripple FIFO, stage 8 is the output end
   always_ff @(posedge clk_i) begin
      if (init) begin
         full_reg <= 9'h000;
         for (int i = 0; i < 9; i++) begin
            fifo_reg[i] <= 8'h00;
         end
      end else begin
         for (int i = 8; i >= 1; i--) begin
            if (full_reg[i - 1] && (!full_reg[i] || (i == 8 && pop))) begin
               fifo_reg[i] <= fifo_reg[i - 1];
               full_reg[i] <= 1'b1;
               full_reg[i - 1] <= 1'b0;
            end
         end
         // R15 pop oldest from last stage
         if (pop && !full_reg[7]) begin
            full_reg[8] <= 1'b0;
         end
         // R5 capture into first stage
         if (key_event && (!full_reg[0] || !full_reg[1])) begin
            fifo_reg[0] <= key_code;
            full_reg[0] <= 1'b1;
         end else if (key_event && &full_reg) begin
            // R13 overflow marks ninth code
            fifo_reg[0] <= {1'b1, fifo_reg[0][6:0]};
         end
         // R14 clear overflow wherever it sits, set wins
         if (sel && cmd == kds_pkg::CMD_CLEAR_OVF) begin
            for (int i = 1; i < 9; i++) begin
               fifo_reg[i][7] <= 1'b0;
            end
            if (!(key_event && &full_reg)) begin
               fifo_reg[0][7] <= 1'b0;
            end
         end
      end
   end

   // R15 and R16 command answers
   always_ff @(posedge clk_i) begin
      if (init) begin
         data_out_reg <= kds_pkg::DATA_RESET;
      end else if (sel) begin
         unique case (cmd)
            kds_pkg::CMD_READ_KEY:
               data_out_reg <= full_reg[8] ? fifo_reg[8] : 8'h00;
            kds_pkg::CMD_READ_STROBE:
               data_out_reg <= 8'h01 << scan_reg[2:0];
            kds_pkg::CMD_READ_RETURN: data_out_reg <= sample_reg;
            default: data_out_reg <= data_out_reg;
         endcase
      end
   end
endmodule
`default_nettype wire

// file: tb/kds_checker.sv
/*
 * Port checker for kds_top: bus reply, strobe scan, display outputs.
 * Assumes one clock; bound to every kds_top instance.
 */
`timescale 1ns/1ps
`default_nettype none
module kds_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic power_on_sync_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   input wire logic [7:0] strobe_o,
   input wire logic [7:0] strobe_oe_o,
   input wire logic bank_select_out_o,
   input wire logic [3:0] group_a_digit_out_o,
   input wire logic [3:0] group_a_digit_oe_o,
   input wire logic [3:0] group_b_digit_out_o
);
   logic [7:0] prev_reg;
   logic [6:0] step_reg;
   logic seen_reg;
   logic chg;
   assign chg = strobe_oe_o != prev_reg;
   ////////////////////////////////////////////////////////////////////////
   // Strobe history; step length trusted only after one full step
   always_ff @(posedge clk_i) begin
      if (rst_i || power_on_sync_i) begin
         prev_reg <= 8'h00;
         step_reg <= 7'h00;
         seen_reg <= 1'b0;
      end else begin
         prev_reg <= strobe_oe_o;
         step_reg <= chg ? 7'h01 : step_reg + 7'h01;
         seen_reg <= seen_reg || (chg && prev_reg != 8'h00);
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i || power_on_sync_i);
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   property p_ack;
      s_take |=> s_ack_pulse;
   endproperty
   a_ack: assert property (p_ack) else $error("ack not one cycle");
   property p_ack_cause;
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
   property p_onehot;
      prev_reg != 8'h00 |-> $onehot(strobe_oe_o);
   endproperty
   a_onehot: assert property (p_onehot) else $error("strobe not one-hot");
   property p_order;
      chg && prev_reg != 8'h00 |-> strobe_oe_o == {prev_reg[6:0], prev_reg[7]};
   endproperty
   a_order: assert property (p_order) else $error("strobe order");
   property p_step;
      seen_reg && chg |-> step_reg == 7'h40;
   endproperty
   a_step: assert property (p_step) else $error("scan step length");
   property p_bank;
      prev_reg != 8'h00 |->
         $changed(bank_select_out_o) == (chg && prev_reg == 8'h80);
   endproperty
   a_bank: assert property (p_bank) else $error("bank select timing");
   property p_drain;
      strobe_o == 8'h00 && group_a_digit_out_o == 4'h0 &&
         group_b_digit_out_o == 4'h0;
   endproperty
   a_drain: assert property (p_drain) else $error("open drain level");
   property p_digit;
      prev_reg != 8'h00 && !wb_ack_o && !$past(wb_ack_o) &&
         !$past(wb_ack_o, 2) && $changed(group_a_digit_oe_o) |-> chg;
   endproperty
   a_digit: assert property (p_digit) else $error("digit off strobe");
   property p_dat_hold;
      $changed(wb_dat_o) |-> wb_ack_o;
   endproperty
   a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
endmodule
bind kds_top kds_checker kds_checker_i (.clk_i(clk_i), .rst_i(rst_i),
   .power_on_sync_i(power_on_sync_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
   .strobe_o(strobe_o), .strobe_oe_o(strobe_oe_o),
   .bank_select_out_o(bank_select_out_o),
   .group_a_digit_out_o(group_a_digit_out_o),
   .group_a_digit_oe_o(group_a_digit_oe_o),
   .group_b_digit_out_o(group_b_digit_out_o));
`default_nettype wire

// file: tb/kds_keypad_model.sv
/*
 * Key matrix with one switch that the bench closes and opens.
 * Assumes returns read high while closed and pulled low when open.
 */
`timescale 1ns/1ps
`default_nettype none
module kds_keypad_model (
   input wire logic [7:0] strobe_oe_i,
   input wire logic press_i,
   input wire logic [2:0] key_strobe_i,
   input wire logic [2:0] key_return_i,
   output logic [7:0] return_o
);
   // Closed switch joins its strobe to its return line
   assign return_o = (press_i && strobe_oe_i[key_strobe_i]) ?
      (8'h01 << key_return_i) : 8'h00;
endmodule
`default_nettype wire

// file: tb/tb_kds_top.sv
/*
 * Self-checking bench for kds_top: bus, display stores, one key entry.
 * Assumes kds_checker is bound and kds_keypad_model sits on the matrix.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
   n_errors++; $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module tb_kds_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic pos = 1'b0;
   logic we = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic press = 1'b0;
   logic [31:0] adr = 32'h0;
   logic [31:0] dat = 32'h0;
   logic [31:0] q;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic bank;
   logic [7:0] ret;
   logic [7:0] strobe_oe;
   logic [3:0] a_oe;
   logic [3:0] b_oe;
   logic [2:0] s = 3'h0;
   logic [2:0] ks = 3'h0;
   logic [2:0] kr = 3'h0;
   int n_errors = 0;
   int samples_checked = 0;
   int n;
   // Short debounce keeps the key test brief
   localparam int DB_FRAMES = 2;
   kds_top #(.DEBOUNCE_FRAMES(DB_FRAMES)) kds_top_i (.clk_i(clk_i),
      .rst_i(rst_i), .power_on_sync_i(pos),
      .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_we_i(we),
      .wb_sel_i(4'hF), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(wb_ack_o),
      .return_in_i(ret), .strobe_o(), .strobe_oe_o(strobe_oe),
      .bank_select_out_o(bank), .group_a_digit_out_o(),
      .group_a_digit_oe_o(a_oe), .group_b_digit_out_o(),
      .group_b_digit_oe_o(b_oe));
   kds_keypad_model kds_keypad_model_i (.strobe_oe_i(strobe_oe),
      .press_i(press), .key_strobe_i(ks), .key_return_i(kr), .return_o(ret));
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] cmd_w(input logic [3:0] c,
      input logic [2:0] st, input logic q7, input logic b8);
      return {23'h0, b8, q7, st, c};
   endfunction
   task automatic step(input int k);
      repeat (k) @(posedge clk_i);
   endtask
   task automatic wb(input logic [31:0] a, input logic w, input logic [31:0] d);
      int t;
      t = 0;
      adr <= a; we <= w; dat <= d; cyc <= 1'b1; stb <= 1'b1;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && t < 50) begin
         @(posedge clk_i);
         t++;
      end
      if (t == 50) n_errors++;
      q = wb_dat_o;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [3:0] a);
      wb({28'h0, a}, 1'b0, 32'h0);
   endtask
   task automatic cmd(input logic [3:0] c);
      wb({28'h0, kds_pkg::REG_CMD}, 1'b1, cmd_w(c, s, 1'b1, 1'b1));
   endtask
   task end_of_test;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge clk_i);
      n_errors++;
      end_of_test;
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h10ed));
      s = 3'($urandom);
      ks = 3'($urandom);
      kr = 3'($urandom);
      step(8);
      rst_i <= 1'b0;
      rd(kds_pkg::REG_STATUS);
      `CHK("status", 10'h200, q[9:0])
      wb(32'h10, 1'b0, 32'h0);
      `CHK("unmapped", 32'h0, q)
      rd(kds_pkg::REG_STRAP);
      `CHK("strap rst", 32'h0, q)
      wb({28'h0, kds_pkg::REG_STRAP}, 1'b1, {29'h0, s});
      rd(kds_pkg::REG_STRAP);
      `CHK("strap", {29'h0, s}, q)
      for (int i = 0; i < 3; i++) begin
         wb({28'h0, kds_pkg::REG_CMD}, 1'b1,
            cmd_w(kds_pkg::CMD_DISP_OFF, s ^ 3'(i == 0), i != 1, i != 2));
         rd(kds_pkg::REG_STATUS);
         `CHK("unselected", 1'b1, q[9])
      end
      for (int c = 2; c < 4; c++) begin
         repeat (16) cmd(4'(c));
         step(140);
         `CHK("digit a", {1'b1, s}, a_oe)
         `CHK("digit b", (c == 3) ? {1'b1, s} : 4'h0, b_oe)
      end
      cmd(kds_pkg::CMD_DISP_OFF);
      step(70);
      `CHK("off", 4'h0, a_oe | b_oe)
      rd(kds_pkg::REG_STATUS);
      `CHK("off flag", 1'b0, q[9])
      cmd(kds_pkg::CMD_DISP_ON);
      step(70);
      `CHK("on", {1'b1, s}, a_oe)
      cmd(kds_pkg::CMD_READ_STROBE);
      rd(kds_pkg::REG_DATA);
      `CHK("strobe read", 1, $countones(q))
      cmd(kds_pkg::CMD_READ_RETURN);
      rd(kds_pkg::REG_DATA);
      `CHK("return read", 32'h0, q)
      press <= 1'b1;
      // Just short of DB_FRAMES scans, just before the earliest accept, as a partial first scan counts as one of the DB_FRAMES + 1 scans
      step(DB_FRAMES * kds_pkg::FRAME_CYCLES - 300);
      rd(kds_pkg::REG_STATUS);
      `CHK("early key", 1'b0, q[8])
      for (n = 0; n < 80 && q[8] !== 1'b1; n++) begin
         step(512);
         rd(kds_pkg::REG_STATUS);
      end
      press <= 1'b0;
      `CHK("fifo one", 10'h300, q[9:0])
      cmd(kds_pkg::CMD_READ_KEY);
      rd(kds_pkg::REG_DATA);
      `CHK("key code", {24'h0, 2'b00, kr, ks}, q)
      cmd(kds_pkg::CMD_CLEAR_OVF);
      rd(kds_pkg::REG_STATUS);
      `CHK("fifo empty", 10'h200, q[9:0])
      pos <= 1'b1;
      step(2);
      pos <= 1'b0;
      step(140);
      `CHK("store clear", 4'h0, a_oe)
      rd(kds_pkg::REG_STRAP);
      `CHK("strap kept", {29'h0, s}, q)
      end_of_test;
   end
endmodule
`default_nettype wire
